// ---- core/sswcg_pkg.sv ----
/*
 Package for the supply supervisor: timing counts, states and carrier structs.
 Assumes a 10 MHz core clock and analog comparator results arriving as levels.
*/
// Notes on behaviour
// - Backup needs supply below threshold and battery
// - Backup flag high exactly while in backup
// - No backup before main supply first present
// - Backup forces reset, idle outputs, low good/line
// - Chip-select passes through unless reset asserted
// - Select high at reset stays high throughout
// - Select low at reset held 12us, then high
// - Decoupled select output driven inactive high
// - Low-line warning asserts ahead of reset
// - Low-line releases only after reset released
// - Manual reset low holds reset asserted
// - Reset held 145ms after manual release
// - Manual reset input debounced internally
// - Kick timeout flags fault, pulse or output low
// - Watchdog timer cleared by reset and edges
// - Periodic 40us opposite-level probe detects floating
// - Watchdog disabled in backup mode
// - Fault output low until next edge or reset
// - Fault tied to manual reset repeats pulses
// - Reset held 145ms after supply recovers
package sswcg_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int CS_HOLD_NS = 12_000;
	localparam int CS_HOLD_CYC = (CS_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int RST_TIMEOUT_MS = 145;
	localparam int RST_TIMEOUT_CYC = RST_TIMEOUT_MS * (CLK_HZ / 1000);
	localparam int WD_TIMEOUT_MS = 1090;
	localparam int WD_TIMEOUT_CYC = WD_TIMEOUT_MS * (CLK_HZ / 1000);
	localparam int PROBE_NS = 40_000;
	localparam int PROBE_CYC = (PROBE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int PROBE_PERIOD_MS = 100;
	localparam int PROBE_PERIOD_CYC = PROBE_PERIOD_MS * (CLK_HZ / 1000);
	localparam int DEBOUNCE_US = 1000;
	localparam int DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1_000_000);
	localparam int CNT_W = 24;

	typedef enum logic [1:0] {CS_PASS, CS_HOLD, CS_BLOCK} sswcg_cs_state_t;

	typedef struct packed {
		logic below_reset_th;
		logic below_backup;
		logic below_low_line;
	} sswcg_cmp_t;

	typedef struct packed {
		logic wd_pull_oe;
		logic wd_pull_level;
	} sswcg_probe_t;
endpackage

// ---- core/sswcg_top.sv ----
/*
 Supply supervisor: backup decision, reset generation, watchdog with
 floating-input probe, and chip-select gating.
 Assumes comparator results and pins are asynchronous; each is synchronised.
*/
`timescale 1ns/1ns
module sswcg_top #(
	parameter int RST_CYC = sswcg_pkg::RST_TIMEOUT_CYC,
	parameter int WD_CYC = sswcg_pkg::WD_TIMEOUT_CYC,
	parameter int PROBE_PER_CYC = sswcg_pkg::PROBE_PERIOD_CYC,
	parameter int DEB_CYC = sswcg_pkg::DEBOUNCE_CYC,
	parameter bit WD_PULSES_RESET = 1'b0
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Comparators
	input wire sswcg_pkg::sswcg_cmp_t cmp_in,
	input wire logic power_fail_cmp_n,
	input wire logic battery_above_min,
	// Host pins
	input wire logic manual_reset_n,
	input wire logic watchdog_kick_in,
	input wire logic chip_sel_in_n,
	// Outputs
	output logic reset_out,
	output logic backup_active_flag,
	output logic battery_good,
	output logic low_line_warn_n,
	output logic power_fail_n,
	output logic watchdog_fault_n,
	output logic chip_sel_out_n,
	output sswcg_pkg::sswcg_probe_t probe_out
);
	localparam int CW = sswcg_pkg::CNT_W;

	//************************************
	// Synchronisers
	//************************************
	logic [7:0] s1_reg;
	logic [7:0] s2_reg;
	wire [7:0] raw = {cmp_in.below_reset_th, cmp_in.below_backup, cmp_in.below_low_line,
		power_fail_cmp_n, battery_above_min, manual_reset_n, watchdog_kick_in, chip_sel_in_n};
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_reg <= 8'hF7;
			s2_reg <= 8'hF7;
		end else begin
			s1_reg <= raw;
			s2_reg <= s1_reg;
		end
	end
	wire below_th = s2_reg[7];
	wire below_bat = s2_reg[6];
	wire below_ll = s2_reg[5];
	wire pf_n = s2_reg[4];
	wire bat_ok = s2_reg[3];
	wire mr_sync_n = s2_reg[2];
	wire kick = s2_reg[1];
	wire cs_in = s2_reg[0];

	//************************************
	// Backup decision
	//************************************
	logic main_seen_reg;
	logic backup_reg;
	wire backup_next = main_seen_reg && below_th && below_bat;
	// Once set, stays set until the next power-on reset
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			main_seen_reg <= 1'b0;
		end else if (!below_th) begin
			main_seen_reg <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			backup_reg <= 1'b0;
		end else begin
			backup_reg <= backup_next;
		end
	end

	//************************************
	// Manual reset debounce
	//************************************
	logic mr_deb_n_reg;
	logic [CW-1:0] deb_cnt_reg;
	wire deb_diff = mr_sync_n != mr_deb_n_reg;
	wire deb_done = deb_cnt_reg == CW'(DEB_CYC - 1);
	// Input must hold its new level for a full count; any bounce restarts it
	wire [CW-1:0] deb_cnt_next = (!deb_diff || deb_done) ? '0 : deb_cnt_reg + 1'b1;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			deb_cnt_reg <= '0;
		end else begin
			deb_cnt_reg <= deb_cnt_next;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mr_deb_n_reg <= 1'b1;
		end else if (deb_diff && deb_done) begin
			mr_deb_n_reg <= mr_sync_n;
		end
	end

	//************************************
	// Reset generator
	//************************************
	// Sources hold the counter at zero; release only after a full timeout
	logic [CW-1:0] rst_cnt_reg;
	logic wd_pulse_reg;
	wire rst_src = below_th || !mr_deb_n_reg || backup_reg || wd_pulse_reg;
	wire rst_done = rst_cnt_reg == CW'(RST_CYC - 1);
	wire rst_next = rst_src || !rst_done;
	wire [CW-1:0] rst_cnt_inc = rst_done ? rst_cnt_reg : rst_cnt_reg + 1'b1;
	wire [CW-1:0] rst_cnt_next = rst_src ? '0 : rst_cnt_inc;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rst_cnt_reg <= '0;
		end else begin
			rst_cnt_reg <= rst_cnt_next;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reset_out <= 1'b1;
		end else begin
			reset_out <= rst_next;
		end
	end
	wire rst_rise = rst_next && !reset_out;

	//************************************
	// Status outputs
	//************************************
	logic ll_hold_reg;
	// Warning latched until reset has released
	wire ll_hold_next = below_ll || (ll_hold_reg && rst_next);
	wire low_line_next = !(below_ll || ll_hold_reg || rst_next || backup_next);
	wire bat_good_next = bat_ok && !backup_next;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ll_hold_reg <= 1'b1;
		end else begin
			ll_hold_reg <= ll_hold_next;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			low_line_warn_n <= 1'b0;
		end else begin
			low_line_warn_n <= low_line_next;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			backup_active_flag <= 1'b0;
		end else begin
			backup_active_flag <= backup_next;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			battery_good <= 1'b0;
		end else begin
			battery_good <= bat_good_next;
		end
	end

	// Power-fail path ignores backup on purpose
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			power_fail_n <= 1'b1;
		end else begin
			power_fail_n <= pf_n;
		end
	end

	//************************************
	// Watchdog and floating probe
	//************************************
	logic kick_d_reg;
	logic [CW-1:0] wd_cnt_reg;
	logic [CW-1:0] probe_cnt_reg;
	logic [CW-1:0] wdp_cnt_reg;
	logic probing_reg;
	logic floating_reg;
	logic probe_lvl_reg;
	wire kick_edge = kick != kick_d_reg;
	wire probe_start = probe_cnt_reg == CW'(PROBE_PER_CYC - 1);
	wire probe_end = probing_reg && probe_cnt_reg == CW'(sswcg_pkg::PROBE_CYC - 1);
	// Edges caused by our own weak pull are not kicks
	wire real_edge = kick_edge && !probing_reg;
	wire wd_off = backup_reg || floating_reg;
	wire wd_clear = rst_rise || real_edge || wd_off;
	wire wd_expire = wd_cnt_reg == CW'(WD_CYC - 1);
	wire wdp_done = wdp_cnt_reg == CW'(RST_CYC - 1);
	wire probe_go = probe_start && !probing_reg;
	wire [CW-1:0] probe_cnt_next = (probe_go || probe_end) ? '0 : probe_cnt_reg + 1'b1;
	wire probe_oe_next = probe_go || (probing_reg && !probe_end);
	// Pull towards the level opposite to what the pin shows now
	wire probe_lvl_next = probe_go ? !kick : probe_lvl_reg;
	// Expiry restarts the count, so a stuck pin faults again and again
	wire [CW-1:0] wd_cnt_next = (wd_clear || wd_expire) ? '0 : wd_cnt_reg + 1'b1;
	wire [CW-1:0] wdp_cnt_next = wd_pulse_reg ? wdp_cnt_reg + 1'b1 : '0;
	wire wd_pulse_set = WD_PULSES_RESET && wd_expire && !wd_clear;
	wire wd_fault_set = !WD_PULSES_RESET && wd_expire;
	// Clear wins over a fault in one cycle: reset and backup force it high
	wire wd_fault_clr = wd_clear || rst_next;
	// Matches the synchroniser's reset level, so no false edge follows reset
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			kick_d_reg <= 1'b1;
		end else begin
			kick_d_reg <= kick;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			probe_cnt_reg <= '0;
		end else begin
			probe_cnt_reg <= probe_cnt_next;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			probing_reg <= 1'b0;
			probe_lvl_reg <= 1'b0;
			floating_reg <= 1'b0;
		end else if (probe_go) begin
			probing_reg <= 1'b1;
			probe_lvl_reg <= !kick;
		end else if (probe_end) begin
			probing_reg <= 1'b0;
			floating_reg <= kick == probe_lvl_reg;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			probe_out <= '0;
		end else begin
			probe_out.wd_pull_oe <= probe_oe_next;
			probe_out.wd_pull_level <= probe_lvl_next;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wd_cnt_reg <= '0;
		end else begin
			wd_cnt_reg <= wd_cnt_next;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wdp_cnt_reg <= '0;
		end else begin
			wdp_cnt_reg <= wdp_cnt_next;
		end
	end

	// Pulse mode stretches reset through the reset generator
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wd_pulse_reg <= 1'b0;
		end else if (wd_pulse_set) begin
			wd_pulse_reg <= 1'b1;
		end else if (wdp_done) begin
			wd_pulse_reg <= 1'b0;
		end
	end

	// Fault output: low on expiry unless WD_PULSES_RESET, back high on edge or reset
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			watchdog_fault_n <= 1'b1;
		end else if (wd_fault_clr) begin
			watchdog_fault_n <= 1'b1;
		end else if (wd_fault_set) begin
			watchdog_fault_n <= 1'b0;
		end
	end

	//************************************
	// Chip-select gating
	//************************************
	// Sampled path adds latency; accepted for a clocked model of the gate
	sswcg_pkg::sswcg_cs_state_t cs_state_reg;
	sswcg_pkg::sswcg_cs_state_t cs_state_next;
	logic [CW-1:0] cs_cnt_reg;
	logic [CW-1:0] cs_cnt_next;
	logic cs_out_next;
	wire cs_hold_done = cs_cnt_reg == CW'(sswcg_pkg::CS_HOLD_CYC - 1);
	// Backup cuts the select at once, whatever the input shows
	wire cs_cut = cs_in || backup_next;
	always_comb begin
		cs_state_next = cs_state_reg;
		cs_cnt_next = cs_cnt_reg;
		cs_out_next = 1'b1;
		unique case (cs_state_reg)
			sswcg_pkg::CS_PASS: begin
				cs_out_next = cs_in;
				if (rst_next) begin
					cs_cnt_next = '0;
					cs_state_next = cs_cut ? sswcg_pkg::CS_BLOCK : sswcg_pkg::CS_HOLD;
					cs_out_next = cs_cut;
				end
			end
			sswcg_pkg::CS_HOLD: begin
				cs_cnt_next = cs_cnt_reg + 1'b1;
				// Hold ends after 12us or when the host ends the access
				if (cs_hold_done || cs_cut) begin
					cs_state_next = sswcg_pkg::CS_BLOCK;
					cs_out_next = 1'b1;
				end else begin
					cs_out_next = 1'b0;
				end
			end
			sswcg_pkg::CS_BLOCK: begin
				cs_out_next = 1'b1;
				if (!rst_next) begin
					cs_state_next = sswcg_pkg::CS_PASS;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cs_state_reg <= sswcg_pkg::CS_BLOCK;
			cs_cnt_reg <= '0;
			chip_sel_out_n <= 1'b1;
		end else begin
			cs_state_reg <= cs_state_next;
			cs_cnt_reg <= cs_cnt_next;
			chip_sel_out_n <= cs_out_next;
		end
	end
endmodule

// ---- verif/sswcg_props.sv ----
/*
 Port checker for the supervisor top.
 Assumes the bind hands on the reset timeout count.
*/
`timescale 1ns/1ns
module sswcg_props #(
	parameter int RST_CYC = 50
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Watched pins
	input wire logic manual_reset_n,
	input wire logic chip_sel_in_n,
	input wire logic reset_out,
	input wire logic backup_active_flag,
	input wire logic battery_good,
	input wire logic low_line_warn_n,
	input wire logic watchdog_fault_n,
	input wire logic chip_sel_out_n
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	int hi_cnt;
	// Length of the current reset run, for the minimum hold
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			hi_cnt <= 0;
		end else begin
			hi_cnt <= reset_out ? hi_cnt + 1 : 0;
		end
	end
	bk_good_low_a: assert property (backup_active_flag |-> !battery_good && reset_out)
		else $error("backup without reset or with battery good");
	bk_outs_idle_a: assert property (backup_active_flag |->
		watchdog_fault_n && chip_sel_out_n && !low_line_warn_n)
		else $error("backup outputs not idle");
	cs_pass_a: assert property ((!reset_out)[*4] |-> chip_sel_out_n == $past(chip_sel_in_n, 3))
		else $error("select not passed through");
	cs_keep_hi_a: assert property (reset_out[*4] ##0 $past(chip_sel_out_n) |-> chip_sel_out_n)
		else $error("select fell during reset");
	cs_hold_end_a: assert property ($rose(reset_out) |-> ##[0:125] chip_sel_out_n)
		else $error("select hold too long");
	ll_after_rst_a: assert property ($rose(low_line_warn_n) |-> !reset_out)
		else $error("low-line released before reset");
	mr_holds_rst_a: assert property ((!manual_reset_n)[*8] |=> reset_out)
		else $error("manual reset not honoured");
	rst_min_hold_a: assert property ($fell(reset_out) |-> hi_cnt >= RST_CYC)
		else $error("reset released too early");
endmodule

bind sswcg_top sswcg_props #(.RST_CYC(RST_CYC)) u_props (.core_clk, .sys_rst, .manual_reset_n,
	.chip_sel_in_n, .reset_out, .backup_active_flag, .battery_good, .low_line_warn_n,
	.watchdog_fault_n, .chip_sel_out_n);

// ---- verif/sswcg_host_model.sv ----
/*
 Host side of the kick pin: strong driver or released line.
 Assumes the device weak pull loses to the strong driver.
*/
`timescale 1ns/1ns
module sswcg_host_model (
	// Host driver
	input wire logic drv_en,
	input wire logic drv_lvl,
	// Device weak pull
	input wire sswcg_pkg::sswcg_probe_t probe_out,
	// Resolved pin
	output logic kick_pin
);
	initial kick_pin = 1'h0;
	// Released line never keeps its last value
	always @(drv_en, drv_lvl, probe_out) begin
		if (drv_en) kick_pin = drv_lvl;
		else if (probe_out.wd_pull_oe) kick_pin = probe_out.wd_pull_level;
		else kick_pin = ~kick_pin;
	end
endmodule

// ---- verif/tb_supply_supervisor_watchdog_ce_gate.sv ----
/*
 Directed bench for the supervisor top.
 Assumes shortened counts: reset 50, watchdog 200, debounce 4, probe period 3000 cycles.
*/
`timescale 1ns/1ns
module tb_supply_supervisor_watchdog_ce_gate;
	localparam int RST = 50;
	logic core_clk = 1'h0;
	logic sys_rst = 1'h1;
	sswcg_pkg::sswcg_cmp_t cmp_in = 3'h7;
	logic pf_n = 1'h1, mr_n = 1'h1, cs_n = 1'h1, drv_en = 1'h1, drv_lvl = 1'h0, bat_in = 1'h1;
	logic kick, rst_o, bk, good, ll_n, pf_o, wdf_n, cs_o;
	sswcg_pkg::sswcg_probe_t probe;
	int n_fail = 0;
	int cmp_count = 0;
	sswcg_top #(.RST_CYC(RST), .WD_CYC(200), .PROBE_PER_CYC(3000), .DEB_CYC(4)) dut_u (
		.core_clk, .sys_rst, .cmp_in, .power_fail_cmp_n(pf_n), .battery_above_min(bat_in),
		.manual_reset_n(mr_n), .watchdog_kick_in(kick), .chip_sel_in_n(cs_n), .reset_out(rst_o),
		.backup_active_flag(bk), .battery_good(good), .low_line_warn_n(ll_n),
		.power_fail_n(pf_o), .watchdog_fault_n(wdf_n), .chip_sel_out_n(cs_o), .probe_out(probe));
	sswcg_host_model host_u (.drv_en, .drv_lvl, .probe_out(probe), .kick_pin(kick));
	initial forever #50 core_clk = ~core_clk;
	task automatic chk(input string nm, input logic exp, input logic got);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s exp %b got %b", nm, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic wait_rel();
		for (int i = 0; i < 400 && rst_o !== 1'h0; i++) cyc(1);
	endtask
	task automatic give_verdict();
		$display("Counts: %0d compares, %0d mismatches", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic t_power();
		cyc(6);
		chk("backup at cold start", 1'h0, bk);
		cmp_in = 3'h0;
		cyc(RST - 5);
		chk("reset after supply up", 1'h1, rst_o);
		wait_rel();
		cyc(2);
		chk("low-line after reset", 1'h1, ll_n);
		chk("battery good", 1'h1, good);
		bat_in = 1'h0;
		cyc(4);
		chk("battery weak", 1'h0, good);
		bat_in = 1'h1;
		$display("t_power done");
	endtask
	task automatic t_cs();
		cs_n = 1'h0;
		cmp_in = 3'h1;
		cyc(5);
		chk("select pass", 1'h0, cs_o);
		chk("early low-line", 1'h0, ll_n);
		chk("no reset yet", 1'h0, rst_o);
		cmp_in = 3'h5;
		cyc(110);
		chk("select held", 1'h0, cs_o);
		cyc(20);
		chk("select cut", 1'h1, cs_o);
		cs_n = 1'h1;
		cyc(4);
		cs_n = 1'h0;
		cyc(4);
		chk("select ignored", 1'h1, cs_o);
		cmp_in = 3'h0;
		wait_rel();
		cyc(4);
		chk("select restored", 1'h0, cs_o);
		cs_n = 1'h1;
		$display("t_cs done");
	endtask
	task automatic t_mr();
		mr_n = 1'h0;
		cyc(1);
		mr_n = 1'h1;
		cyc(8);
		chk("glitch ignored", 1'h0, rst_o);
		for (int i = 0; i < 6; i++) begin
			mr_n = i[0];
			cyc(1);
		end
		mr_n = 1'h0;
		cyc(12);
		chk("manual reset", 1'h1, rst_o);
		cs_n = 1'h0;
		cyc(4);
		chk("select high kept", 1'h1, cs_o);
		cs_n = 1'h1;
		mr_n = 1'h1;
		cyc(RST - 2);
		chk("reset timeout", 1'h1, rst_o);
		wait_rel();
		chk("reset released", 1'h0, rst_o);
		$display("t_mr done");
	endtask
	task automatic t_wd();
		for (int i = 0; i < 3; i++) begin
			drv_lvl = ~drv_lvl;
			cyc(150);
			chk("kick keeps fault off", 1'h1, wdf_n);
		end
		cyc(90);
		chk("watchdog fault", 1'h0, wdf_n);
		cyc(40);
		chk("fault stays", 1'h0, wdf_n);
		drv_lvl = ~drv_lvl;
		cyc(6);
		chk("fault cleared", 1'h1, wdf_n);
		$display("t_wd done");
	endtask
	// Host lets go of the kick pin; the next probe must find it floating
	task automatic t_float();
		logic k0;
		drv_en = 1'h0;
		cyc(4);
		k0 = kick;
		for (int i = 0; i < 3500 && probe.wd_pull_oe !== 1'h1; i++) cyc(1);
		chk("probe level", ~k0, probe.wd_pull_level);
		cyc(398);
		chk("probe still on", 1'h1, probe.wd_pull_oe);
		cyc(2);
		chk("probe off", 1'h0, probe.wd_pull_oe);
		cyc(300);
		chk("floating disables watchdog", 1'h1, wdf_n);
		$display("t_float done");
	endtask
	task automatic t_bk();
		cmp_in = 3'h5;
		cyc(6);
		chk("no backup above battery", 1'h0, bk);
		cmp_in = 3'h7;
		cyc(6);
		chk("backup entered", 1'h1, bk);
		chk("battery good low", 1'h0, good);
		chk("reset in backup", 1'h1, rst_o);
		pf_n = 1'h0;
		cyc(5);
		chk("power fail passed", 1'h0, pf_o);
		$display("t_bk done");
	endtask
	initial begin
		cyc(20);
		sys_rst = 1'h0;
		t_power();
		t_cs();
		t_mr();
		t_wd();
		t_float();
		t_bk();
		give_verdict();
	end
	// Run needs about 4000 cycles
	initial begin
		#1000000;
		n_fail++;
		$display("Watchdog expired");
		give_verdict();
	end
endmodule
